// ===== design/dag_top.sv
module dag_top (
    input  wire logic              REF_CLK,
    input  wire logic              SYS_RST,
    input  wire logic [15:0]       ADDR,
    input  wire logic [15:0]       WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic [15:0]            RDATA,
    input  wire dag_pkg::dag_req_t X_REQ,
    input  wire dag_pkg::dag_req_t Y_REQ,
    output dag_pkg::dag_rsp_t      X_RSP,
    output dag_pkg::dag_rsp_t      Y_RSP
);

    logic [15:0] circular_control_reg;
    logic [15:0] x_circ_start;
    logic [15:0] x_circ_end;
    logic [15:0] y_circ_start;
    logic [15:0] y_circ_end;
    logic [15:0] reverse_modifier_reg;
    logic        x_circ_enable;
    logic        y_circ_enable;
    logic        reverse_enable;
    logic [3:0]  x_circ_pointer_select;
    logic [3:0]  y_circ_pointer_select;
    logic [3:0]  reverse_pointer_select;
    logic [14:0] reverse_pivot;
    logic        x_circ_hit;
    logic        y_circ_hit;
    logic        x_rev_hit;
    logic [15:0] x_reg_sum;
    logic [15:0] x_lit_sum;
    dag_pkg::dag_rsp_t next_x_rsp;
    dag_pkg::dag_rsp_t next_y_rsp;

    // field views of the control registers
    assign x_circ_enable          = circular_control_reg[dag_pkg::X_EN_BIT];
    assign y_circ_enable          = circular_control_reg[dag_pkg::Y_EN_BIT];
    assign x_circ_pointer_select  = circular_control_reg[dag_pkg::XSEL_LSB +: 4];
    assign y_circ_pointer_select  = circular_control_reg[dag_pkg::YSEL_LSB +: 4];
    assign reverse_pointer_select = circular_control_reg[dag_pkg::RSEL_LSB +: 4];
    assign reverse_enable         = reverse_modifier_reg[dag_pkg::REV_EN_BIT];
    assign reverse_pivot          = reverse_modifier_reg[14:0];

    // circular / reverse apply only to the selected pointer
    assign x_circ_hit = x_circ_enable && (x_circ_pointer_select != dag_pkg::NO_PTR)
                        && (x_circ_pointer_select == X_REQ.ptr_sel);
    assign y_circ_hit = y_circ_enable && (y_circ_pointer_select != dag_pkg::NO_PTR)
                        && (y_circ_pointer_select == Y_REQ.ptr_sel);
    assign x_rev_hit  = reverse_enable && (reverse_pointer_select != dag_pkg::NO_PTR)
                        && (reverse_pointer_select == X_REQ.ptr_sel);

    // helper sums watched by the checks below
    assign x_reg_sum = X_REQ.ptr + X_REQ.base;
    assign x_lit_sum = X_REQ.ptr + {{6{X_REQ.lit[9]}}, X_REQ.lit};

    // reverses a 15-bit word index
    function automatic logic [14:0] rev15(input logic [14:0] v);
        logic [14:0] r;
        r = '0;
        for (int i = 0; i < 15; i++) begin
            r[i] = v[14 - i];
        end
        return r;
    endfunction

    // one generator; called once for X and once for Y
    function automatic dag_pkg::dag_rsp_t calc(
        input dag_pkg::dag_req_t q,
        input logic              circ_on,
        input logic              rev_on,
        input logic [15:0]       lo,
        input logic [15:0]       hi,
        input logic [14:0]       pivot,
        input logic              is_y
    );
        dag_pkg::dag_rsp_t r;
        logic [15:0] step;
        logic [15:0] off;
        logic [15:0] raw;
        logic [15:0] len;
        logic [15:0] fixed;
        logic [15:0] brv;
        logic        inc;
        logic        rev;
        logic        circ;
        logic [16:0] sum;
        r    = '0;
        step = q.byte_acc ? dag_pkg::BYTE_STEP : dag_pkg::WORD_STEP;
        // Y takes only word reads of multiply-accumulate class
        r.valid    = q.valid && (!is_y || (q.mac && !q.write && !q.byte_acc));
        r.ptr_sel  = q.ptr_sel;
        r.op1_sel  = q.base_sel;
        r.default_working_reg_sel = q.ptr_sel;
        // reverse only for data-space word writes with an incrementing mode
        rev = rev_on && !is_y && !q.prog && q.write && !q.byte_acc
              && (q.mode == dag_pkg::DAG_POST_INC || q.mode == dag_pkg::DAG_PRE_INC);
        // reverse wins over X circular on writes
        circ = circ_on && !rev;
        case (q.mode)
            dag_pkg::DAG_POST_INC, dag_pkg::DAG_PRE_INC: off = step;
            dag_pkg::DAG_POST_DEC, dag_pkg::DAG_PRE_DEC: off = 16'h0000 - step;
            dag_pkg::DAG_REG_OFF:                        off = q.base;
            dag_pkg::DAG_LIT_OFF:                        off = {{6{q.lit[9]}}, q.lit};
            default:                                     off = 16'h0000;
        endcase
        inc = !off[15];
        // one bit wider so a buffer touching either end of memory still sees its crossing
        sum = {1'b0, q.ptr} + {1'b0, off};
        raw = sum[15:0];
        // length from the bounds; a full 64K span wraps to zero, which still adds right
        len = hi - lo + dag_pkg::ONE;
        // beyond the bound, not merely equal, so large steps still land right
        r.wrapped = circ && (off != 16'h0000) && (inc ? (sum[16] || raw > hi) : (!sum[16] || raw < lo));
        fixed = r.wrapped ? (inc ? raw - len : raw + len) : raw;
        // reversed-carry add of the pivot; the mode's own step is ignored
        brv = {rev15(rev15(q.ptr[15:1]) + rev15(pivot)), 1'b0};
        r.brev = rev;
        case (q.mode)
            dag_pkg::DAG_FILE: begin
                r.ea_valid  = 1'b1;
                r.ea        = q.is_move ? q.faddr : (q.faddr & dag_pkg::NEAR_MASK);
                r.default_working_reg_sel  = dag_pkg::DEFAULT_WORKING_REG_ZERO;
                r.dest_default_working_reg = q.dest_default_working_reg;
                r.op2_src   = dag_pkg::OP2_MEM;
            end
            dag_pkg::DAG_REG_DIRECT: begin
                r.op2_src = dag_pkg::OP2_REG;
            end
            dag_pkg::DAG_LITERAL: begin
                r.op2_src = dag_pkg::OP2_LIT;
                r.lit_val = q.lit5 ? {11'h000, q.lit[4:0]} : {6'h00, q.lit};
            end
            dag_pkg::DAG_IND: begin
                r.ea_valid = 1'b1;
                r.ea       = q.ptr;
                r.op2_src  = dag_pkg::OP2_MEM;
            end
            dag_pkg::DAG_POST_INC, dag_pkg::DAG_POST_DEC: begin
                r.ea_valid = 1'b1;
                r.ea       = q.ptr;
                r.ptr_we   = 1'b1;
                r.ptr_new  = rev ? brv : fixed;
                r.circ     = circ;
                r.op2_src  = dag_pkg::OP2_MEM;
            end
            dag_pkg::DAG_PRE_INC, dag_pkg::DAG_PRE_DEC: begin
                r.ea_valid = 1'b1;
                r.ptr_we   = 1'b1;
                r.ptr_new  = rev ? brv : fixed;
                r.ea       = rev ? brv : fixed;
                r.circ     = circ;
                r.op2_src  = dag_pkg::OP2_MEM;
            end
            dag_pkg::DAG_REG_OFF, dag_pkg::DAG_LIT_OFF: begin
                // offset forms are corrected but never write the pointer back
                r.ea_valid = 1'b1;
                r.ea       = fixed;
                r.circ     = circ;
                r.op2_src  = dag_pkg::OP2_MEM;
            end
            default: begin
                r.ea_valid = 1'b0;
            end
        endcase
        // word-only space: bit zero of every address held clear
        if (is_y) begin
            r.ea[0]      = 1'b0;
            r.ptr_new[0] = 1'b0;
        end
        if (!r.valid) begin
            r = '0;
        end
        return r;
    endfunction

    // both generators work side by side in the same cycle
    always_comb begin
        next_x_rsp = calc(X_REQ, x_circ_hit, x_rev_hit, x_circ_start, x_circ_end,
                          reverse_pivot, 1'b0);
        next_y_rsp = calc(Y_REQ, y_circ_hit, 1'b0, y_circ_start, y_circ_end,
                          reverse_pivot, 1'b1);
    end

    // answers registered, one cycle after the request
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            X_RSP <= '0;
            Y_RSP <= '0;
        end else begin
            X_RSP <= next_x_rsp;
            Y_RSP <= next_y_rsp;
        end
    end

    // register writes; start bit 0 reads 0 and end bit 0 reads 1
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            circular_control_reg <= dag_pkg::CIRC_CTRL_RESET;
            x_circ_start         <= dag_pkg::START_RESET;
            x_circ_end           <= dag_pkg::END_RESET;
            y_circ_start         <= dag_pkg::START_RESET;
            y_circ_end           <= dag_pkg::END_RESET;
            reverse_modifier_reg <= dag_pkg::REVERSE_RESET;
        end else if (WR) begin
            case (ADDR)
                dag_pkg::ADDR_CIRC_CTRL: circular_control_reg <= WDATA & dag_pkg::CIRC_CTRL_MASK;
                dag_pkg::ADDR_X_START:   x_circ_start         <= {WDATA[15:1], 1'b0};
                dag_pkg::ADDR_X_END:     x_circ_end           <= {WDATA[15:1], 1'b1};
                dag_pkg::ADDR_Y_START:   y_circ_start         <= {WDATA[15:1], 1'b0};
                dag_pkg::ADDR_Y_END:     y_circ_end           <= {WDATA[15:1], 1'b1};
                dag_pkg::ADDR_REVERSE:   reverse_modifier_reg <= WDATA;
                default: begin
                end
            endcase
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            case (ADDR)
                dag_pkg::ADDR_CIRC_CTRL: RDATA <= circular_control_reg;
                dag_pkg::ADDR_X_START:   RDATA <= x_circ_start;
                dag_pkg::ADDR_X_END:     RDATA <= x_circ_end;
                dag_pkg::ADDR_Y_START:   RDATA <= y_circ_start;
                dag_pkg::ADDR_Y_END:     RDATA <= y_circ_end;
                dag_pkg::ADDR_REVERSE:   RDATA <= reverse_modifier_reg;
                dag_pkg::ADDR_STATUS:    RDATA <= {11'h000, Y_RSP.wrapped, X_RSP.wrapped,
                                                   X_RSP.brev, Y_RSP.circ, X_RSP.circ};
                default:                 RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // checks
    sequence s_x_req(dag_pkg::dag_mode_t m);
        X_REQ.valid && X_REQ.mode == m;
    endsequence

    sequence s_x_circ_inside;
        X_REQ.valid && x_circ_hit && !X_REQ.write && !X_REQ.byte_acc
        && X_REQ.ptr >= x_circ_start && X_REQ.ptr <= x_circ_end
        && (X_REQ.mode == dag_pkg::DAG_POST_INC || X_REQ.mode == dag_pkg::DAG_POST_DEC);
    endsequence

    property p_y_mac_only;
        @(posedge REF_CLK) disable iff (SYS_RST)
        Y_REQ.valid && (Y_REQ.write || Y_REQ.byte_acc || !Y_REQ.mac) |=> !Y_RSP.valid;
    endproperty
    a_y_mac_only: assert property (p_y_mac_only) else $error("Y answered a non-MAC access");

    property p_y_even;
        @(posedge REF_CLK) disable iff (SYS_RST)
        Y_RSP.valid |-> !Y_RSP.ea[0] && !Y_RSP.ptr_new[0];
    endproperty
    a_y_even: assert property (p_y_even) else $error("Y address has bit zero set");

    property p_file_near;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_x_req(dag_pkg::DAG_FILE) and (X_REQ.is_move == 1'b0)
        |=> X_RSP.ea[15:13] == 3'h0 && X_RSP.default_working_reg_sel == dag_pkg::DEFAULT_WORKING_REG_ZERO;
    endproperty
    a_file_near: assert property (p_file_near) else $error("file address outside near space");

    property p_move_full;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_x_req(dag_pkg::DAG_FILE) and (X_REQ.is_move == 1'b1) |=> X_RSP.ea == $past(X_REQ.faddr);
    endproperty
    a_move_full: assert property (p_move_full) else $error("move address truncated");

    property p_ind_plain;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_x_req(dag_pkg::DAG_IND) |=> X_RSP.ea == $past(X_REQ.ptr) && !X_RSP.ptr_we;
    endproperty
    a_ind_plain: assert property (p_ind_plain) else $error("plain indirect address wrong");

    property p_post_mod;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_x_req(dag_pkg::DAG_POST_DEC) |=> X_RSP.ea == $past(X_REQ.ptr) && X_RSP.ptr_we;
    endproperty
    a_post_mod: assert property (p_post_mod) else $error("post-modify used new pointer");

    property p_pre_mod;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_x_req(dag_pkg::DAG_PRE_DEC) |=> X_RSP.ea == X_RSP.ptr_new && X_RSP.ptr_we
            && (X_RSP.wrapped || X_RSP.ea == $past(X_REQ.ptr)
                - ($past(X_REQ.byte_acc) ? dag_pkg::BYTE_STEP : dag_pkg::WORD_STEP));
    endproperty
    a_pre_mod: assert property (p_pre_mod) else $error("pre-modify address not updated pointer");

    property p_reg_off;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_x_req(dag_pkg::DAG_REG_OFF) and (x_circ_hit == 1'b0)
        |=> X_RSP.ea == $past(x_reg_sum) && !X_RSP.ptr_we;
    endproperty
    a_reg_off: assert property (p_reg_off) else $error("register offset sum wrong");

    property p_lit_off;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_x_req(dag_pkg::DAG_LIT_OFF) and (x_circ_hit == 1'b0) |=> X_RSP.ea == $past(x_lit_sum);
    endproperty
    a_lit_off: assert property (p_lit_off) else $error("literal offset sum wrong");

    property p_x_circ_off;
        @(posedge REF_CLK) disable iff (SYS_RST)
        X_REQ.valid && (!x_circ_enable || x_circ_pointer_select == dag_pkg::NO_PTR) |=> !X_RSP.circ;
    endproperty
    a_x_circ_off: assert property (p_x_circ_off) else $error("X circular while disabled");

    property p_circ_stays_in;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s_x_circ_inside |=> X_RSP.ptr_new >= x_circ_start && X_RSP.ptr_new <= x_circ_end;
    endproperty
    a_circ_stays_in: assert property (p_circ_stays_in) else $error("circular pointer left buffer");

    property p_y_circ_off;
        @(posedge REF_CLK) disable iff (SYS_RST)
        Y_REQ.valid && (!y_circ_enable || y_circ_pointer_select == dag_pkg::NO_PTR) |=> !Y_RSP.circ;
    endproperty
    a_y_circ_off: assert property (p_y_circ_off) else $error("Y circular while disabled");

    property p_rev_gate;
        @(posedge REF_CLK) disable iff (SYS_RST)
        X_REQ.valid && (!X_REQ.write || X_REQ.byte_acc || X_REQ.prog || !x_rev_hit
                        || (X_REQ.mode != dag_pkg::DAG_POST_INC && X_REQ.mode != dag_pkg::DAG_PRE_INC))
        |=> !X_RSP.brev;
    endproperty
    a_rev_gate: assert property (p_rev_gate) else $error("reverse applied outside its mode");

    property p_op1_direct;
        @(posedge REF_CLK) disable iff (SYS_RST)
        X_REQ.valid |=> X_RSP.op1_sel == $past(X_REQ.base_sel);
    endproperty
    a_op1_direct: assert property (p_op1_direct) else $error("first operand not the base register");

    property p_wrap_len;
        @(posedge REF_CLK) disable iff (SYS_RST)
        (s_x_req(dag_pkg::DAG_POST_INC) and (X_REQ.write == 1'b0)) ##1 X_RSP.wrapped
        |-> X_RSP.ptr_new == $past(X_REQ.ptr) + ($past(X_REQ.byte_acc) ? dag_pkg::BYTE_STEP : dag_pkg::WORD_STEP)
            - ($past(x_circ_end) - $past(x_circ_start) + dag_pkg::ONE);
    endproperty
    a_wrap_len: assert property (p_wrap_len) else $error("wrap moved by wrong length");

endmodule

// ===== shared/dag_pkg.sv
package dag_pkg;

    // register addresses on the core register port
    localparam logic [15:0] ADDR_CIRC_CTRL = 16'h0046;
    localparam logic [15:0] ADDR_X_START   = 16'h0048;
    localparam logic [15:0] ADDR_X_END     = 16'h004a;
    localparam logic [15:0] ADDR_Y_START   = 16'h004c;
    localparam logic [15:0] ADDR_Y_END     = 16'h004e;
    localparam logic [15:0] ADDR_REVERSE   = 16'h0050;
    localparam logic [15:0] ADDR_STATUS    = 16'h0054;

    // values after reset
    localparam logic [15:0] CIRC_CTRL_RESET = 16'h0000;
    localparam logic [15:0] START_RESET     = 16'h0000;
    localparam logic [15:0] END_RESET       = 16'h0001;
    localparam logic [15:0] REVERSE_RESET   = 16'h0000;

    // field positions
    localparam int X_EN_BIT   = 15;
    localparam int Y_EN_BIT   = 14;
    localparam int REV_EN_BIT = 15;
    localparam int XSEL_LSB   = 0;
    localparam int YSEL_LSB   = 4;
    localparam int RSEL_LSB   = 8;
    localparam logic [15:0] CIRC_CTRL_MASK = 16'hcfff;
    localparam logic [3:0]  NO_PTR         = 4'hf;
    localparam logic [3:0]  DEFAULT_WORKING_REG_ZERO      = 4'h0;

    // address arithmetic constants
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam logic [15:0] ONE       = 16'h0001;
    localparam logic [15:0] NEAR_MASK = 16'h1fff;

    typedef enum logic [3:0] {
        DAG_FILE       = 4'h0,
        DAG_REG_DIRECT = 4'h1,
        DAG_LITERAL    = 4'h2,
        DAG_IND        = 4'h3,
        DAG_POST_INC   = 4'h4,
        DAG_POST_DEC   = 4'h5,
        DAG_PRE_INC    = 4'h6,
        DAG_PRE_DEC    = 4'h7,
        DAG_REG_OFF    = 4'h8,
        DAG_LIT_OFF    = 4'h9
    } dag_mode_t;

    typedef enum logic [1:0] {
        OP2_REG = 2'h0,
        OP2_MEM = 2'h1,
        OP2_LIT = 2'h2
    } dag_op2_t;

    typedef struct packed {
        logic        valid;
        dag_mode_t   mode;
        logic [3:0]  ptr_sel;
        logic [15:0] ptr;
        logic [3:0]  base_sel;
        logic [15:0] base;
        logic [9:0]  lit;
        logic        lit5;
        logic [15:0] faddr;
        logic        is_move;
        logic        dest_default_working_reg;
        logic        write;
        logic        byte_acc;
        logic        prog;
        logic        mac;
    } dag_req_t;

    typedef struct packed {
        logic        valid;
        logic        ea_valid;
        logic [15:0] ea;
        logic        ptr_we;
        logic [3:0]  ptr_sel;
        logic [15:0] ptr_new;
        logic [3:0]  op1_sel;
        logic [3:0]  default_working_reg_sel;
        logic        dest_default_working_reg;
        dag_op2_t    op2_src;
        logic [15:0] lit_val;
        logic        circ;
        logic        wrapped;
        logic        brev;
    } dag_rsp_t;

endpackage

// ===== verif/dag_core_model.sv
module dag_core_model (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire dag_pkg::dag_rsp_t x_rsp,
    input  wire dag_pkg::dag_rsp_t y_rsp,
    input  wire logic [3:0]        rd_sel,
    output logic [15:0]            rd_val
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] default_working_reg [16];

    // pointer file; y first so x wins a clash on one register
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                default_working_reg[i] <= 16'h0000;
            end
        end else begin
            if (y_rsp.valid && y_rsp.ptr_we) begin
                default_working_reg[y_rsp.ptr_sel] <= y_rsp.ptr_new;
            end
            if (x_rsp.valid && x_rsp.ptr_we) begin
                default_working_reg[x_rsp.ptr_sel] <= x_rsp.ptr_new;
            end
        end
    end

    // datapath reads the pointer combinationally
    assign rd_val = default_working_reg[rd_sel];
endmodule

// ===== verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic              ref_clk;
    logic              sys_rst;
    logic              wr;
    logic              rd;
    logic [15:0]       addr;
    logic [15:0]       wdata;
    logic [15:0]       rdata;
    logic [15:0]       rd_val;
    dag_pkg::dag_req_t x_req;
    dag_pkg::dag_req_t y_req;
    dag_pkg::dag_rsp_t x_rsp;
    dag_pkg::dag_rsp_t y_rsp;
    int                fail_count;
    int                n_compared;

    dag_top uut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .X_REQ(x_req), .Y_REQ(y_req), .X_RSP(x_rsp), .Y_RSP(y_rsp));
    dag_core_model core (.clk(ref_clk), .rst(sys_rst), .x_rsp(x_rsp), .y_rsp(y_rsp), .rd_sel(4'h3),
        .rd_val(rd_val));

    task automatic summarize;
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // one request per generator, answer checked in its single cycle
    task automatic go(input dag_pkg::dag_req_t xr, input dag_pkg::dag_req_t yr);
        @(posedge ref_clk);
        x_req <= xr;
        y_req <= yr;
        @(posedge ref_clk);
        x_req <= '0;
        y_req <= '0;
        #1;
    endtask

    function automatic dag_pkg::dag_req_t mk(input dag_pkg::dag_mode_t m, input logic [3:0] s,
                                             input logic [15:0] p);
        dag_pkg::dag_req_t r;
        r = '0;
        r.valid = 1'b1;
        r.mode = m;
        r.ptr_sel = s;
        r.ptr = p;
        r.mac = 1'b1;
        return r;
    endfunction

    task automatic t_regs;
        logic [15:0] d;
        logic [15:0] a [8] = '{16'h0046, 16'h0048, 16'h004a, 16'h004c, 16'h004e, 16'h0050, 16'h0054, 16'h0060};
        logic [15:0] rv [8] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
        logic [15:0] wv [8] = '{16'hcfff, 16'hfffe, 16'hffff, 16'hfffe, 16'hffff, 16'hffff, 16'h0000, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            reg_rd(a[i], d);
            chk(d, rv[i]);
            reg_wr(a[i], 16'hffff);
            reg_rd(a[i], d);
            chk(d, wv[i]);
        end
        reg_wr(dag_pkg::ADDR_CIRC_CTRL, 16'h0000);
    endtask

    task automatic t_linear;
        dag_pkg::dag_req_t r;
        dag_pkg::dag_mode_t md [7] = '{dag_pkg::DAG_IND, dag_pkg::DAG_POST_INC, dag_pkg::DAG_POST_DEC,
            dag_pkg::DAG_PRE_INC, dag_pkg::DAG_PRE_DEC, dag_pkg::DAG_REG_OFF, dag_pkg::DAG_LIT_OFF};
        logic [15:0] ea [7] = '{16'h1234, 16'h1234, 16'h1234, 16'h1236, 16'h1232, 16'h1244, 16'h1232};
        logic [15:0] nw [7] = '{16'h0000, 16'h1236, 16'h1233, 16'h1236, 16'h1232, 16'h0000, 16'h0000};
        for (int i = 0; i < 7; i++) begin
            r = mk(md[i], 4'h3, 16'h1234);
            r.base_sel = 4'h5;
            r.base = 16'h0010;
            r.lit = 10'h3fe;
            r.byte_acc = (i == 2);
            go(r, '0);
            chk(x_rsp.ea, ea[i]);
            chk({15'h0, x_rsp.ptr_we}, {15'h0, nw[i] != 16'h0000});
            chk(x_rsp.ptr_new & {16{x_rsp.ptr_we}}, nw[i]);
            chk({12'h0, x_rsp.op1_sel}, 16'h0005);
            chk({14'h0, x_rsp.op2_src}, {14'h0, dag_pkg::OP2_MEM});
        end
        chk(rd_val, 16'h1232);
        r = mk(dag_pkg::DAG_FILE, 4'h3, 16'h1234);
        r.faddr = 16'hffff;
        r.dest_default_working_reg = 1'b1;
        go(r, '0);
        chk(x_rsp.ea, 16'h1fff);
        chk({12'h0, x_rsp.default_working_reg_sel}, 16'h0000);
        chk({15'h0, x_rsp.dest_default_working_reg}, 16'h0001);
        r.is_move = 1'b1;
        go(r, '0);
        chk(x_rsp.ea, 16'hffff);
        r = mk(dag_pkg::DAG_LITERAL, 4'h3, 16'h1234);
        r.lit = 10'h3ff;
        go(r, '0);
        chk(x_rsp.lit_val, 16'h03ff);
        chk({14'h0, x_rsp.op2_src}, {14'h0, dag_pkg::OP2_LIT});
        r.lit5 = 1'b1;
        go(r, '0);
        chk(x_rsp.lit_val, 16'h001f);
        r.mode = dag_pkg::DAG_REG_DIRECT;
        go(r, '0);
        chk({14'h0, x_rsp.op2_src}, {14'h0, dag_pkg::OP2_REG});
    endtask

    task automatic t_y;
        dag_pkg::dag_req_t r;
        go(mk(dag_pkg::DAG_IND, 4'h3, 16'h0555), mk(dag_pkg::DAG_POST_INC, 4'h4, 16'h2001));
        chk(x_rsp.ea, 16'h0555);
        chk(y_rsp.ea, 16'h2000);
        chk(y_rsp.ptr_new, 16'h2002);
        // write, byte and non-mac reads are all turned away
        for (int i = 0; i < 3; i++) begin
            r = mk(dag_pkg::DAG_IND, 4'h4, 16'h2000);
            r.write = (i == 0);
            r.byte_acc = (i == 1);
            r.mac = (i != 2);
            go('0, r);
            chk({15'h0, y_rsp.valid}, 16'h0000);
            chk(y_rsp.ea, 16'h0000);
        end
    endtask

    task automatic t_circ;
        dag_pkg::dag_req_t r;
        logic [15:0] cv [3] = '{16'h8002, 16'h0002, 16'h800f};
        logic [3:0] sv [3] = '{4'h3, 4'h2, 4'hf};
        reg_wr(dag_pkg::ADDR_X_START, 16'h1000);
        reg_wr(dag_pkg::ADDR_X_END, 16'h100f);
        reg_wr(dag_pkg::ADDR_CIRC_CTRL, 16'h8002);
        r = mk(dag_pkg::DAG_POST_INC, 4'h2, 16'h100e);
        r.prog = 1'b1;
        go(r, '0);
        chk(x_rsp.ea, 16'h100e);
        chk(x_rsp.ptr_new, 16'h1000);
        chk({14'h0, x_rsp.circ, x_rsp.wrapped}, 16'h0003);
        r.byte_acc = 1'b1;
        go(r, '0);
        chk(x_rsp.ptr_new, 16'h100f);
        go(mk(dag_pkg::DAG_PRE_DEC, 4'h2, 16'h1000), '0);
        chk(x_rsp.ea, 16'h100e);
        r = mk(dag_pkg::DAG_LIT_OFF, 4'h2, 16'h100e);
        r.lit = 10'h00a;
        go(r, '0);
        chk(x_rsp.ea, 16'h1008);
        chk({15'h0, x_rsp.ptr_we}, 16'h0000);
        // wrong pointer, enable clear and reserved selector each stay linear
        for (int i = 0; i < 3; i++) begin
            reg_wr(dag_pkg::ADDR_CIRC_CTRL, cv[i]);
            go(mk(dag_pkg::DAG_POST_INC, sv[i], 16'h100e), '0);
            chk(x_rsp.ptr_new, 16'h1010);
        end
        // buffer at the top of memory: the step carries out of 16 bits
        reg_wr(dag_pkg::ADDR_X_START, 16'h8000);
        reg_wr(dag_pkg::ADDR_X_END, 16'hffff);
        reg_wr(dag_pkg::ADDR_CIRC_CTRL, 16'h8002);
        go(mk(dag_pkg::DAG_POST_INC, 4'h2, 16'hfffe), '0);
        chk(x_rsp.ptr_new, 16'h8000);
        reg_wr(dag_pkg::ADDR_Y_START, 16'h2000);
        reg_wr(dag_pkg::ADDR_Y_END, 16'h2007);
        reg_wr(dag_pkg::ADDR_CIRC_CTRL, 16'h4040);
        go('0, mk(dag_pkg::DAG_POST_INC, 4'h4, 16'h2006));
        chk(y_rsp.ptr_new, 16'h2000);
        chk({15'h0, y_rsp.wrapped}, 16'h0001);
        reg_wr(dag_pkg::ADDR_CIRC_CTRL, 16'h0040);
        go('0, mk(dag_pkg::DAG_POST_INC, 4'h4, 16'h2006));
        chk(y_rsp.ptr_new, 16'h2008);
    endtask

    task automatic t_rev;
        dag_pkg::dag_req_t r;
        logic [15:0] nw [7] = '{16'h0010, 16'hfffe, 16'h0002, 16'h0002, 16'h0001, 16'h0002, 16'h0002};
        reg_wr(dag_pkg::ADDR_CIRC_CTRL, 16'h0200);
        reg_wr(dag_pkg::ADDR_REVERSE, 16'h8008);
        for (int i = 0; i < 7; i++) begin
            r = mk(dag_pkg::DAG_POST_INC, 4'h2, 16'h0000);
            r.write = (i != 2);
            r.prog = (i == 3);
            r.byte_acc = (i == 4);
            if (i == 1) begin
                r.mode = dag_pkg::DAG_POST_DEC;
            end
            if (i == 5) begin
                r.ptr_sel = 4'h3;
            end
            if (i == 6) begin
                reg_wr(dag_pkg::ADDR_REVERSE, 16'h0008);
            end
            go(r, '0);
            chk({15'h0, x_rsp.brev}, {15'h0, i == 0});
            chk(x_rsp.ptr_new, nw[i]);
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        summarize;
    end

    initial begin
        logic [15:0] d;
        sys_rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 16'h0000;
        x_req = '0;
        y_req = '0;
        fail_count = 0;
        n_compared = 0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs;
        t_linear;
        t_y;
        t_circ;
        t_rev;
        // second reset mid-run must restore the reverse modifier value
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        reg_rd(dag_pkg::ADDR_REVERSE, d);
        chk(d, dag_pkg::REVERSE_RESET);
        summarize;
    end
endmodule
